/* src/cgs_ctrl_regs.sv */
// Two-wire serial slave, control registers and output gating of the clock generator
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Registers take their default values only at power-up reset, never otherwise.
// [RULE_02] Master sends command code then byte count bytes before register data.
// [RULE_03] Command code and byte count bytes are acknowledged and their contents ignored.
// [RULE_04] Data bytes then fill register 0, 1, 2 onward, each acknowledged.
// [RULE_05] Register 0 bit 7 picks spread depth: 0 is 1.5 percent, 1 is 0.5.
// [RULE_06] Register 0 bit 3 picks frequency source: strap, or software code bits 6:4.
// [RULE_07] Eight software codes map to fixed processor and bus frequency pairs.
// [RULE_08] Register 0 bit 2 picks center spread (0) or down spread (1).
// [RULE_09] Register 0 bit 1 enables spread-spectrum modulation.
// [RULE_10] Register 0 bit 0 set places all clock outputs in high impedance.
// [RULE_11] Register 0 powers up as all zeros.
// [RULE_12] Register 1 bits 3:0 enable processor clocks; all bits default one.
// [RULE_13] Register 2 bit 6 enables free bus clock, bits 5:0 bus clocks.
// [RULE_14] Register 3 bits 7:0 enable memory clocks 7 to 0, default one.
// [RULE_15] Register 4 bits 3:0 enable memory clocks 11 to 8, default one.
// [RULE_16] Slave answers address 1101 001 and drives acknowledge low per byte.
// [RULE_17] A clock runs only if its register bit and hardware stop both allow.
// [RULE_18] Stopped clocks sit low; the last high period is never shortened.
// [RULE_19] Reserved bits have no effect; bytes past register 4 are acknowledged, dropped.
module cgs_ctrl_regs (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        SDCLK,
  input  wire logic        SDATA_I,
  output logic             SDATA_O,
  output logic             SDATA_OE_N,
  input  wire logic [2:0]  HW_FREQ_STRAP,
  input  wire logic        PROC_STOP_N,
  input  wire logic        BUS_STOP_N,
  input  wire logic        SRC_PROC_CLK,
  input  wire logic        SRC_BUS_CLK,
  input  wire logic        SRC_MEM_CLK,
  input  wire logic        SRC_REF_CLK,
  output logic [3:0]       PROC_CLK_OUT,
  output logic [5:0]       BUS_CLK_OUT,
  output logic             FREE_BUS_CLK_OUT,
  output logic [11:0]      MEM_CLK_OUT,
  output logic             REF_CLK_OUT,
  output logic             INTC_CLK_OUT,
  output logic             CLK_OE_N,
  output logic [2:0]       FREQ_CODE,
  output logic             SPREAD_DEPTH_FINE,
  output logic             SPREAD_DOWN,
  output logic             SPREAD_ENABLE
);

  // ----------------------------------------------------------------
  // Bus line sampling and conditions
  // ----------------------------------------------------------------
  cgs_pkg::cgs_state_e state_r;
  cgs_pkg::cgs_state_e state_nxt;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [3:0] cnt_r;
  logic [7:0] shreg_r;
  logic [1:0] fill_r;
  logic [2:0] idx_r;
  logic       drive_low_r;
  logic [7:0] regs_r [cgs_pkg::NUM_REGS];

  wire scl_rise  = SDCLK & ~scl_d_r;
  wire scl_fall  = ~SDCLK & scl_d_r;
  wire start_cnd = SDCLK & scl_d_r & sda_d_r & ~SDATA_I;
  wire stop_cnd  = SDCLK & scl_d_r & ~sda_d_r & SDATA_I;

  // Byte decode: the address is in the upper seven bits of the shifter
  wire        addr_match = (shreg_r[7:1] == cgs_pkg::SLAVE_ADDR);
  wire        rd_mode    = shreg_r[0];
  wire        wr_commit  = (state_r == cgs_pkg::CGS_WRITE) && scl_fall && (cnt_r == cgs_pkg::CNT_ACK);
  wire        is_filler  = (fill_r < cgs_pkg::NUM_FILLERS);
  wire        in_range   = (idx_r < cgs_pkg::IDX_LAST_P1);
  wire [7:0]  rd_byte    = in_range ? regs_r[idx_r] : 8'h00;
  wire [7:0]  rd_shift   = {shreg_r[6:0], 1'b0};

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= SDCLK;
      sda_d_r <= SDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Slave sequencer
  // ----------------------------------------------------------------
  // Next state; a start always restarts address reception, a stop always frees the line
  always_comb begin
    state_nxt = state_r;
    if (start_cnd) begin
      state_nxt = cgs_pkg::CGS_ADDR;
    end else if (stop_cnd) begin
      state_nxt = cgs_pkg::CGS_IDLE;
    end else begin
      case (state_r)
        cgs_pkg::CGS_ADDR: begin
          if (scl_fall && cnt_r == cgs_pkg::CNT_ACK && !addr_match) begin
            state_nxt = cgs_pkg::CGS_IDLE;
          end else if (scl_fall && cnt_r == cgs_pkg::CNT_ACK_HOLD) begin
            state_nxt = rd_mode ? cgs_pkg::CGS_READ : cgs_pkg::CGS_WRITE;
          end
        end
        cgs_pkg::CGS_READ: begin
          // Master not-acknowledge ends the read-back
          if (scl_rise && cnt_r == cgs_pkg::CNT_ACK && SDATA_I) begin
            state_nxt = cgs_pkg::CGS_IDLE;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= cgs_pkg::CGS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit counter, shifter and line drive
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_r       <= 4'h0;
      shreg_r     <= 8'h00;
      drive_low_r <= 1'b0;
    end else if (start_cnd || stop_cnd || state_nxt == cgs_pkg::CGS_IDLE) begin
      cnt_r       <= 4'h0;
      drive_low_r <= 1'b0;
    end else if (state_r == cgs_pkg::CGS_READ) begin
      if (scl_rise && cnt_r < cgs_pkg::CNT_ACK) begin
        cnt_r <= cnt_r + 4'h1;
      end else if (scl_rise && cnt_r == cgs_pkg::CNT_ACK) begin
        cnt_r <= cgs_pkg::CNT_ACK_HOLD;
      end else if (scl_fall && cnt_r == cgs_pkg::CNT_ACK) begin
        drive_low_r <= 1'b0;  // Release for the master's acknowledge
      end else if (scl_fall && cnt_r == cgs_pkg::CNT_ACK_HOLD) begin
        shreg_r     <= rd_byte;
        drive_low_r <= ~rd_byte[7];
        cnt_r       <= 4'h0;
      end else if (scl_fall && cnt_r != 4'h0) begin
        shreg_r     <= rd_shift;
        drive_low_r <= ~rd_shift[7];
      end
    end else if (scl_rise && cnt_r < cgs_pkg::CNT_ACK) begin
      shreg_r <= {shreg_r[6:0], SDATA_I};
      cnt_r   <= cnt_r + 4'h1;
    end else if (scl_fall && cnt_r == cgs_pkg::CNT_ACK) begin
      drive_low_r <= 1'b1;  // RULE_16 RULE_03 RULE_04 RULE_19
      cnt_r       <= cgs_pkg::CNT_ACK_HOLD;
    end else if (scl_fall && cnt_r == cgs_pkg::CNT_ACK_HOLD) begin
      cnt_r <= 4'h0;
      if (state_r == cgs_pkg::CGS_ADDR && rd_mode) begin
        shreg_r     <= rd_byte;
        drive_low_r <= ~rd_byte[7];
      end else begin
        drive_low_r <= 1'b0;
      end
    end
  end

  // Filler count and register pointer; the pointer saturates so late bytes are dropped
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      fill_r <= 2'h0;
      idx_r  <= 3'h0;
    end else if (start_cnd) begin
      fill_r <= 2'h0;
      idx_r  <= 3'h0;
    end else if (wr_commit && is_filler) begin
      fill_r <= fill_r + 2'h1;  // RULE_02 RULE_03
    end else if ((wr_commit || (state_r == cgs_pkg::CGS_READ && scl_fall && cnt_r == cgs_pkg::CNT_ACK))
                 && in_range) begin
      idx_r <= idx_r + 3'h1;  // RULE_04 RULE_19
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // Defaults come from the power-up reset only; no bus event restores them
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      regs_r[cgs_pkg::IDX_SPREAD]  <= cgs_pkg::RST_SPREAD;   // RULE_01 RULE_11
      regs_r[cgs_pkg::IDX_PROC_EN] <= cgs_pkg::RST_PROC_EN;  // RULE_12
      regs_r[cgs_pkg::IDX_BUS_EN]  <= cgs_pkg::RST_BUS_EN;   // RULE_13
      regs_r[cgs_pkg::IDX_MEM_LO]  <= cgs_pkg::RST_MEM_LO;   // RULE_14
      regs_r[cgs_pkg::IDX_MEM_HI]  <= cgs_pkg::RST_MEM_HI;   // RULE_15
    end else if (wr_commit && !is_filler && in_range) begin
      regs_r[idx_r] <= shreg_r;  // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // Frequency selection and spread controls
  // ----------------------------------------------------------------
  // Strap is caught once after reset release, not by the reset itself
  logic       strap_taken_r;
  logic [2:0] strap_r;
  logic [2:0] freq_r;
  logic       depth_r;
  logic       down_r;
  logic       spen_r;
  logic       oe_n_r;
  wire  [7:0] r0 = regs_r[cgs_pkg::IDX_SPREAD];
  wire  [2:0] freq_sel = r0[cgs_pkg::BIT_SOFT_SRC] ? r0[cgs_pkg::BIT_CODE_HI:cgs_pkg::BIT_CODE_LO] : strap_r;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_taken_r <= 1'b0;
      strap_r       <= 3'h0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      strap_r       <= HW_FREQ_STRAP;
    end
  end

  // Code goes to the synthesizer, which owns the frequency pair table
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      freq_r  <= 3'h0;
      depth_r <= 1'b0;
      down_r  <= 1'b0;
      spen_r  <= 1'b0;
      oe_n_r  <= 1'b0;
    end else begin
      freq_r  <= freq_sel;                      // RULE_06 RULE_07
      depth_r <= r0[cgs_pkg::BIT_DEPTH];        // RULE_05
      down_r  <= r0[cgs_pkg::BIT_DOWN];         // RULE_08
      spen_r  <= r0[cgs_pkg::BIT_SPREAD_EN];    // RULE_09
      oe_n_r  <= r0[cgs_pkg::BIT_TRISTATE];     // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  // Reserved bits never reach an enable; hardware stops are ANDed in
  wire [3:0]  proc_en = regs_r[cgs_pkg::IDX_PROC_EN][3:0] & {4{PROC_STOP_N}};  // RULE_12 RULE_17 RULE_19
  wire [6:0]  bus_en  = {regs_r[cgs_pkg::IDX_BUS_EN][cgs_pkg::BIT_FREE_BUS],
                         regs_r[cgs_pkg::IDX_BUS_EN][5:0] & {6{BUS_STOP_N}}};    // RULE_13 RULE_17
  wire [11:0] mem_en  = {regs_r[cgs_pkg::IDX_MEM_HI][3:0], regs_r[cgs_pkg::IDX_MEM_LO]};  // RULE_14 RULE_15
  wire [6:0]  bus_out;

  cgs_clk_gate #(.W(4)) u_proc (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .src_clk(SRC_PROC_CLK),
                                .enable(proc_en), .clk_out(PROC_CLK_OUT));
  cgs_clk_gate #(.W(7)) u_bus (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .src_clk(SRC_BUS_CLK),
                               .enable(bus_en), .clk_out(bus_out));
  cgs_clk_gate #(.W(12)) u_mem (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .src_clk(SRC_MEM_CLK),
                                .enable(mem_en), .clk_out(MEM_CLK_OUT));
  cgs_clk_gate #(.W(2)) u_ref (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .src_clk(SRC_REF_CLK),
                               .enable(2'h3), .clk_out({INTC_CLK_OUT, REF_CLK_OUT}));

  assign BUS_CLK_OUT       = bus_out[5:0];
  assign FREE_BUS_CLK_OUT  = bus_out[6];
  assign SDATA_O           = 1'b0;  // Open drain: only ever pulls low
  assign SDATA_OE_N        = ~drive_low_r;
  assign CLK_OE_N          = oe_n_r;
  assign FREQ_CODE         = freq_r;
  assign SPREAD_DEPTH_FINE = depth_r;
  assign SPREAD_DOWN       = down_r;
  assign SPREAD_ENABLE     = spen_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_addr_done;
    state_r == cgs_pkg::CGS_ADDR && scl_fall && cnt_r == cgs_pkg::CNT_ACK && addr_match && !start_cnd && !stop_cnd;
  endsequence

  a_addr_ack_low: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_16
    s_addr_done |=> !SDATA_OE_N)
    else $error("address not acknowledged");
  a_filler_no_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_03
    wr_commit && is_filler |=> regs_r[0] == $past(regs_r[0]) && !SDATA_OE_N)
    else $error("filler byte altered registers or was not acknowledged");
  a_write_order: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_04
    wr_commit && !is_filler && idx_r == cgs_pkg::IDX_PROC_EN |=> regs_r[1] == $past(shreg_r))
    else $error("data byte not placed in register order");
  a_regs_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_01
    !wr_commit |=> regs_r[0] == $past(regs_r[0]) && regs_r[2] == $past(regs_r[2]))
    else $error("register changed without a write");
  a_soft_source: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_06
    r0[cgs_pkg::BIT_SOFT_SRC] |=> FREQ_CODE == $past(r0[cgs_pkg::BIT_CODE_HI:cgs_pkg::BIT_CODE_LO]))
    else $error("software frequency code not selected");
  a_hw_source: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_06
    !r0[cgs_pkg::BIT_SOFT_SRC] && strap_taken_r |=> FREQ_CODE == $past(strap_r))
    else $error("strap frequency not selected");
  a_spread_ctl: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_05 RULE_08 RULE_09
    ##1 {SPREAD_DEPTH_FINE, SPREAD_DOWN, SPREAD_ENABLE} ==
        $past({r0[cgs_pkg::BIT_DEPTH], r0[cgs_pkg::BIT_DOWN], r0[cgs_pkg::BIT_SPREAD_EN]}))
    else $error("spread controls do not follow register");
  a_tristate_all: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_10
    $rose(r0[cgs_pkg::BIT_TRISTATE]) |=> CLK_OE_N)
    else $error("outputs not released on tristate");
  a_proc_stop: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_17
    !PROC_STOP_N && $past(!PROC_STOP_N) && !$past(SRC_PROC_CLK) |=> PROC_CLK_OUT == 4'h0)
    else $error("processor clock ran while stopped");

endmodule : cgs_ctrl_regs

/* src/cgs_pkg.sv */
// Constants shared by the clock generator serial control register block
package cgs_pkg;

  // ----------------------------------------------------------------
  // Register bank layout
  // ----------------------------------------------------------------
  localparam int          NUM_REGS      = 5;
  localparam logic [2:0]  IDX_SPREAD    = 3'h0;  // spread_and_frequency_select
  localparam logic [2:0]  IDX_PROC_EN   = 3'h1;  // processor_clock_enable
  localparam logic [2:0]  IDX_BUS_EN    = 3'h2;  // bus_clock_enable
  localparam logic [2:0]  IDX_MEM_LO    = 3'h3;  // memory_clock_enable_low
  localparam logic [2:0]  IDX_MEM_HI    = 3'h4;  // memory_clock_enable_high
  localparam logic [2:0]  IDX_LAST_P1   = 3'h5;  // Saturated write pointer value

  // ----------------------------------------------------------------
  // Power-up values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_SPREAD    = 8'h00;
  localparam logic [7:0]  RST_PROC_EN   = 8'hff;
  localparam logic [7:0]  RST_BUS_EN    = 8'h7f;
  localparam logic [7:0]  RST_MEM_LO    = 8'hff;
  localparam logic [7:0]  RST_MEM_HI    = 8'h0f;

  // ----------------------------------------------------------------
  // Field positions of spread_and_frequency_select and bus_clock_enable
  // ----------------------------------------------------------------
  localparam int          BIT_DEPTH     = 7;
  localparam int          BIT_CODE_HI   = 6;
  localparam int          BIT_CODE_LO   = 4;
  localparam int          BIT_SOFT_SRC  = 3;
  localparam int          BIT_DOWN      = 2;
  localparam int          BIT_SPREAD_EN = 1;
  localparam int          BIT_TRISTATE  = 0;
  localparam int          BIT_FREE_BUS  = 6;

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  localparam logic [6:0]  SLAVE_ADDR    = 7'h69;  // Write form 1101 0010
  localparam logic [1:0]  NUM_FILLERS   = 2'h2;   // Command code, byte count
  localparam logic [3:0]  CNT_ACK       = 4'h8;
  localparam logic [3:0]  CNT_ACK_HOLD  = 4'h9;

  typedef enum logic [1:0] {
    CGS_IDLE  = 2'b00,
    CGS_ADDR  = 2'b01,
    CGS_WRITE = 2'b11,
    CGS_READ  = 2'b10
  } cgs_state_e;

endpackage : cgs_pkg

/* src/cgs_clk_gate.sv */
// Glitch-free gate for a group of clock outputs sharing one source
`timescale 1ns/1ps
module cgs_clk_gate #(
  parameter int W = 4
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RESET_N,
  input  wire logic         src_clk,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] clk_out
);

  // Refuse a gate with no outputs when the design is elaborated
  if (W < 1) begin : g_bad_width
    $error("cgs_clk_gate: W must be at least 1");
  end

  logic [W-1:0] en_hold_r;
  logic [W-1:0] out_r;

  // Enable is only resampled while the source is low, so a high phase is never cut
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      en_hold_r <= '0;
      out_r     <= '0;
    end else begin
      if (!src_clk) begin
        en_hold_r <= enable;  // RULE_18
      end
      out_r <= {W{src_clk}} & en_hold_r;  // RULE_17
    end
  end

  assign clk_out = out_r;

  // Outputs only fall while the source is low: high periods stay whole
  a_no_trunc_high: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_18
    $fell(out_r[0]) |-> !$past(src_clk, 1))
    else $error("clock output high period truncated");

  // A running output keeps its held enable for the whole high phase
  a_gate_needs_en: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // RULE_17
    out_r[0] |-> en_hold_r[0] && $past(src_clk, 1))
    else $error("clock output ran while disabled");

endmodule : cgs_clk_gate

/* bench/cgs_bus_master.sv */
// Behavioural two-wire bus controller that drives the control register slave
`timescale 1ns/1ps
module cgs_bus_master (
  input  wire logic CLK_SYS,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv_n
);
  int half = 4;  // Cycles per clock phase; raise it to act as a slow controller
  initial begin
    scl       = 1'b1;
    sda_drv_n = 1'b1;
  end
  // ----------------------------------------------------------------
  // Bit level: every change lands just after a rising edge
  // ----------------------------------------------------------------
  task automatic bit_cyc(input logic b, output logic s);
    @(posedge CLK_SYS);
    sda_drv_n <= b;  // Data only moves while the serial clock is low
    repeat (half) @(posedge CLK_SYS);
    scl <= 1'b1;
    repeat (half) @(posedge CLK_SYS);
    s = sda_in;
    scl <= 1'b0;
  endtask : bit_cyc
  task automatic start_cond;
    @(posedge CLK_SYS);
    sda_drv_n <= 1'b0;
    repeat (half) @(posedge CLK_SYS);
    scl <= 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    @(posedge CLK_SYS);
    sda_drv_n <= 1'b0;
    repeat (half) @(posedge CLK_SYS);
    scl <= 1'b1;
    repeat (half) @(posedge CLK_SYS);
    sda_drv_n <= 1'b1;
    repeat (half) @(posedge CLK_SYS);
  endtask : stop_cond
  // ----------------------------------------------------------------
  // Byte and frame level
  // ----------------------------------------------------------------
  task automatic byte_out(input logic [7:0] d, inout int nacks);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
    bit_cyc(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask : byte_out
  task automatic write_frame(input logic [7:0] addr, input logic [7:0] data[$], output int nacks);
    nacks = 0;
    start_cond();
    byte_out(addr, nacks);
    byte_out(8'ha5, nacks);
    byte_out(8'h3c, nacks);
    foreach (data[i]) byte_out(data[i], nacks);
    stop_cond();
  endtask : write_frame
  // Reads n bytes; the last one is refused so the slave lets go of the line
  task automatic read_frame(input int n, output logic [7:0] q[$]);
    int         dummy;
    logic       s;
    logic [7:0] b;
    q = {};
    dummy = 0;
    start_cond();
    byte_out(8'hd3, dummy);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_cyc(1'b1, s);
        b[i] = s;
      end
      bit_cyc(k == n - 1, s);
      q.push_back(b);
    end
    stop_cond();
  endtask : read_frame
endmodule : cgs_bus_master

/* bench/test_clock_gen_serial_control_regs.sv */
// Self-checking bench for the clock generator serial control registers
`timescale 1ns/1ps
module test_clock_gen_serial_control_regs;
  localparam logic [2:0] STRAP = 3'h5;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        proc_stop_n = 1'b1;
  logic        bus_stop_n = 1'b1;
  logic [3:0]  src_cnt = 4'h0;
  logic        sdclk, sdata_i, sdata_o, sdata_oe_n, sda_drv_n;
  logic [3:0]  proc_clk;
  logic [5:0]  bus_clk;
  logic [11:0] mem_clk;
  logic [2:0]  freq_code;
  logic        free_bus_clk, ref_clk, intc_clk, clk_oe_n, depth_fine, spread_down, spread_en;
  logic [7:0]  wq[$];
  int          checks = 0;
  int          n_fail = 0;
  // ----------------------------------------------------------------
  // Clock, synthesizer sources and the open-drain data wire
  // ----------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) src_cnt <= src_cnt + 4'h1;
  // Pull-up on the wire: high unless some party pulls it low
  assign sdata_i = sda_drv_n & (sdata_oe_n | sdata_o);
  cgs_ctrl_regs cgs_ctrl_regs_inst (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .SDCLK(sdclk), .SDATA_I(sdata_i), .SDATA_O(sdata_o),
    .SDATA_OE_N(sdata_oe_n), .HW_FREQ_STRAP(STRAP), .PROC_STOP_N(proc_stop_n), .BUS_STOP_N(bus_stop_n),
    .SRC_PROC_CLK(src_cnt[1]), .SRC_BUS_CLK(src_cnt[2]), .SRC_MEM_CLK(src_cnt[1]),
    .SRC_REF_CLK(src_cnt[2]), .PROC_CLK_OUT(proc_clk), .BUS_CLK_OUT(bus_clk),
    .FREE_BUS_CLK_OUT(free_bus_clk), .MEM_CLK_OUT(mem_clk), .REF_CLK_OUT(ref_clk),
    .INTC_CLK_OUT(intc_clk), .CLK_OE_N(clk_oe_n), .FREQ_CODE(freq_code),
    .SPREAD_DEPTH_FINE(depth_fine), .SPREAD_DOWN(spread_down), .SPREAD_ENABLE(spread_en));
  cgs_bus_master cgs_bus_master_inst (.CLK_SYS(clk_sys), .sda_in(sdata_i), .scl(sdclk), .sda_drv_n(sda_drv_n));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] addr, input int exp_nacks);
    int nacks;
    cgs_bus_master_inst.write_frame(addr, wq, nacks);
    chk("nacks", exp_nacks, nacks);
  endtask : wr
  task automatic rd_check(input logic [7:0] exp[$]);
    logic [7:0] q[$];
    cgs_bus_master_inst.read_frame(exp.size(), q);
    foreach (exp[i]) chk("readback", exp[i], q[i]);
  endtask : rd_check
  // Collects which outputs went high; enables settle first since gating waits for a low source
  task automatic observe(input logic [24:0] exp);
    logic [24:0] seen;
    seen = '0;
    repeat (8) @(posedge clk_sys);
    repeat (48) begin
      @(negedge clk_sys);
      seen |= {ref_clk, intc_clk, proc_clk, bus_clk, free_bus_clk, mem_clk};
    end
    @(posedge clk_sys);  // Hand back on a rising edge so callers drive inputs there
    chk("running", exp, seen);
  endtask : observe
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    chk("freq_code", STRAP, freq_code);
    chk("spread", 4'h0, {depth_fine, spread_down, spread_en, clk_oe_n});
    observe(25'h1ffffff);
    rd_check({8'h00, 8'hff, 8'h7f, 8'hff, 8'h0f, 8'h00});
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_codes;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      wq = {{c[0], c, 1'b1, c[1], c[2], 1'b0}};
      wr(8'hd2, 0);
      chk("freq_code", c, freq_code);
      chk("depth", c[0], depth_fine);
      chk("down", c[1], spread_down);
      chk("spread_en", c[2], spread_en);
    end
    wq = {8'h70};
    wr(8'hd2, 0);
    chk("freq_code", STRAP, freq_code);
    $display("test codes done");
  endtask : t_codes
  task automatic t_enables;
    wq = {8'h00, 8'hf5, 8'hca, 8'h3c, 8'hf9, 8'h77};
    wr(8'hd2, 0);
    rd_check({8'h00, 8'hf5, 8'hca, 8'h3c, 8'hf9, 8'h00});
    observe({2'b11, 4'h5, 6'h0a, 1'b1, 4'h9, 8'h3c});
    proc_stop_n <= 1'b0;
    bus_stop_n  <= 1'b0;
    observe({2'b11, 4'h0, 6'h00, 1'b1, 4'h9, 8'h3c});
    proc_stop_n <= 1'b1;
    bus_stop_n  <= 1'b1;
    $display("test enables done");
  endtask : t_enables
  // Slow controller here, to show the slave waits on long clock phases
  task automatic t_tristate;
    cgs_bus_master_inst.half = 9;
    wq = {8'h01};
    wr(8'hd2, 0);
    chk("clk_oe_n", 1'b1, clk_oe_n);
    wq = {8'h00};
    wr(8'hd2, 0);
    chk("clk_oe_n", 1'b0, clk_oe_n);
    cgs_bus_master_inst.half = 4;
    $display("test tristate done");
  endtask : t_tristate
  task automatic t_bad_addr;
    wq = {8'h55};
    wr(8'hd4, 4);
    rd_check({8'h00, 8'hf5});
    $display("test bad address done");
  endtask : t_bad_addr
  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_defaults();
    t_codes();
    t_enables();
    t_tristate();
    t_bad_addr();
    summarize();
  end
  // The whole run needs roughly 7200 cycles; about eight times that means a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    summarize();
  end
endmodule : test_clock_gen_serial_control_regs
